// *** hdl/lbp_core.sv ***
// Purpose: Per-channel PWM bypass control, fault posting, staged updates, watchdogs
// Assumes: Frame decoding and CRC checking sit upstream on mclk; pwmTick comes from the divider
// Notes:   oscClk is a free-running local oscillator used only by the clock watchdog

// Overview of operation
// - Post pending fault at off-compare count
// - Fault visible within one 1024-step period
// - Overvoltage closes bypass immediately, no clock
// - Frame writes commit together after frame end
// - Bad-CRC frame writes are discarded
// - Compare values are 10 bits over two bytes
// - New off value activates at on match
// - New on value activates at off match
// - Equal compare values mean channel off
// - Off match wins over on match
// - Watchdogs idle until their enable bits set
// - Clock watchdog on oscillator, comm on mclk
// - Clock stalled 32 oscillator cycles forces defaults
// - While clock lost, hold bus and registers
// - Works with clock stopped if watchdog off
// - No valid frame for 2^22 cycles forces defaults
// - Valid CRC frame ends comm watchdog forcing
// - Forced state comes from default LED register
// - Counter wraps 0..1023, on opens, off closes
// - Compare enable gates channel switching
// - Writing fault bit zero clears latch
// - No short-threshold crossing by period end faults
module lbp_core
  import lbp_pkg::*;
#(
  parameter int unsigned COMM_WD_CYCLES = COMM_WD_CYCLES_DFLT
)
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              oscClk,
  input  wire lbp_req_s          busReq,
  input  wire lbp_frame_s        frameIn,
  input  wire logic              pwmTick,
  input  wire logic [CH_NUM-1:0] overvoltageDetect,
  input  wire logic [CH_NUM-1:0] shortAbove,
  output logic      [DATA_W-1:0] rdData,
  output logic      [CH_NUM-1:0] ledLit,
  output logic                   uartHold
);

  localparam int               CW_W      = $clog2(COMM_WD_CYCLES + 1);
  localparam logic [CW_W-1:0]  COMM_LAST = CW_W'(COMM_WD_CYCLES - 1);
  localparam logic [5:0]       OSC_LAST  = 6'(CLK_WD_OSC_CYCLES - 1);

  // ==========================================================================
  // Helpers
  function automatic logic [ADDR_W-1:0] chAdr(input logic [ADDR_W-1:0] base, input int ch);
    chAdr = base + ADDR_W'(ch);
  endfunction

  function automatic logic [CH_NUM-1:0] merge12(input logic [CH_NUM-1:0] cur,
                                                input logic [7:0] lo, input logic [7:0] hi,
                                                input logic dLo, input logic dHi);
    logic [CH_NUM-1:0] mask;
    mask    = {{4{dHi}}, {8{dLo}}};
    merge12 = (cur & ~mask) | ({hi[3:0], lo} & mask);
  endfunction

  function automatic logic [DATA_W-1:0] hiByte(input logic [CNT_W-1:0] v);
    hiByte = {6'h00, v[9:8]};
  endfunction

  // ==========================================================================
  // Declarations
  logic [DATA_W-1:0]  stage_r [REG_COUNT];
  logic [REG_COUNT-1:0] dirty_r;
  logic [CNT_W-1:0]   onHold_r  [CH_NUM];
  logic [CNT_W-1:0]   offHold_r [CH_NUM];
  logic [CNT_W-1:0]   onAct_r   [CH_NUM];
  logic [CNT_W-1:0]   offAct_r  [CH_NUM];
  logic [CH_NUM-1:0]  enable_r;
  logic [CH_NUM-1:0]  default_led_state_register_r;
  logic [1:0]         system_config_register_r;
  logic [CNT_W-1:0]   cnt_r;
  logic               stepped_r;
  logic [CH_NUM-1:0]  matchOn;
  logic [CH_NUM-1:0]  matchOff;
  logic [CH_NUM-1:0]  ledOn_r;
  logic [CH_NUM-1:0]  ovS1_r;
  logic [CH_NUM-1:0]  ovSync_r;
  logic [CH_NUM-1:0]  shS1_r;
  logic [CH_NUM-1:0]  shSync_r;
  logic [CH_NUM-1:0]  ovLatch_r;
  logic [CH_NUM-1:0]  wasOn_r;
  logic [CH_NUM-1:0]  shortSeen_r;
  logic [CH_NUM-1:0]  faultPend_r;
  logic [CH_NUM-1:0]  fault_r;
  logic [CH_NUM-1:0]  faultClr;
  logic [CH_NUM-1:0]  shortMiss;
  logic               periodEnd;
  logic               commit;
  logic               frameBad;
  lbp_wd_e            commState_r;
  logic [CW_W-1:0]    commCnt_r;
  logic               commExpired;
  logic               clkToggle_r;
  logic               tgS1_r;
  logic               tgS2_r;
  logic               tgS3_r;
  logic               enS1_r;
  logic               enS2_r;
  logic [5:0]         oscCnt_r;
  logic               clkLost_r;
  logic               lostS1_r;
  logic               lostS2_r;
  logic [DATA_W-1:0]  rdNext;

  assign commit   = frameIn.done & frameIn.crcOk;
  assign frameBad = frameIn.done & ~frameIn.crcOk;
  assign uartHold = lostS2_r;

  // ==========================================================================
  // Frame staging
  // A write landing in the same cycle as frame end belongs to no frame and is dropped
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dirty_r <= '0;
      for (int a = 0; a < REG_COUNT; a++)
      begin
        stage_r[a] <= 8'h00;
      end
    end
    else if (frameIn.done)
    begin
      dirty_r <= '0;
    end
    else if (busReq.wr && !uartHold && busReq.addr < ADR_LIMIT)
    begin
      stage_r[busReq.addr] <= busReq.wdata;
      dirty_r[busReq.addr] <= 1'b1;
    end
  end

  // ==========================================================================
  // Holding registers, committed as one unit
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int ch = 0; ch < CH_NUM; ch++)
      begin
        onHold_r[ch]  <= RST_COUNT;
        offHold_r[ch] <= RST_COUNT;
      end
    end
    else if (commit)
    begin
      for (int ch = 0; ch < CH_NUM; ch++)
      begin
        if (dirty_r[chAdr(ADR_ON_LO, ch)])
          onHold_r[ch][7:0] <= stage_r[chAdr(ADR_ON_LO, ch)];
        if (dirty_r[chAdr(ADR_ON_HI, ch)])
          onHold_r[ch][9:8] <= stage_r[chAdr(ADR_ON_HI, ch)][1:0];
        if (dirty_r[chAdr(ADR_OFF_LO, ch)])
          offHold_r[ch][7:0] <= stage_r[chAdr(ADR_OFF_LO, ch)];
        if (dirty_r[chAdr(ADR_OFF_HI, ch)])
          offHold_r[ch][9:8] <= stage_r[chAdr(ADR_OFF_HI, ch)][1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_r <= RST_CHAN;
      default_led_state_register_r <= RST_CHAN;
      system_config_register_r <= RST_SYSTEM_CONFIG_REGISTER;
    end
    else if (commit)
    begin
      enable_r <= merge12(enable_r, stage_r[ADR_CHANNEL_COMPARE_ENABLE_LO], stage_r[ADR_CHANNEL_COMPARE_ENABLE_HI],
                          dirty_r[ADR_CHANNEL_COMPARE_ENABLE_LO], dirty_r[ADR_CHANNEL_COMPARE_ENABLE_HI]);
      default_led_state_register_r <= merge12(default_led_state_register_r, stage_r[ADR_DEFAULT_LED_STATE_REGISTER_LO], stage_r[ADR_DEFAULT_LED_STATE_REGISTER_HI],
                          dirty_r[ADR_DEFAULT_LED_STATE_REGISTER_LO], dirty_r[ADR_DEFAULT_LED_STATE_REGISTER_HI]);
      if (dirty_r[ADR_SYSTEM_CONFIG_REGISTER])
        system_config_register_r <= stage_r[ADR_SYSTEM_CONFIG_REGISTER][1:0];
    end
  end

  // ==========================================================================
  // Period counter
  // Nothing here needs a minimum clock rate, so a stopped mclk just freezes state
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r     <= RST_COUNT;
      stepped_r <= 1'b0;
    end
    else
    begin
      if (pwmTick)
        cnt_r <= cnt_r + 10'h001;
      stepped_r <= pwmTick;
    end
  end

  assign periodEnd = stepped_r & (cnt_r == RST_COUNT);

  for (genvar i = 0; i < CH_NUM; i++)
  begin : g_match
    assign matchOn[i]  = stepped_r & (cnt_r == onAct_r[i]);
    assign matchOff[i] = stepped_r & (cnt_r == offAct_r[i]);
  end

  // ==========================================================================
  // Synchronous compare update
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int ch = 0; ch < CH_NUM; ch++)
      begin
        onAct_r[ch]  <= RST_COUNT;
        offAct_r[ch] <= RST_COUNT;
      end
    end
    else
    begin
      for (int ch = 0; ch < CH_NUM; ch++)
      begin
        if (matchOff[ch])
          onAct_r[ch] <= onHold_r[ch];
        if (matchOn[ch])
          offAct_r[ch] <= offHold_r[ch];
      end
    end
  end

  // ==========================================================================
  // Bypass switch state, 1 means LED lit
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      ledOn_r <= '0;
    else
      ledOn_r <= enable_r & ~matchOff & (ledOn_r | matchOn);
  end

  // ==========================================================================
  // Fault detection and posting
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovS1_r   <= '0;
      ovSync_r <= '0;
      shS1_r   <= '0;
      shSync_r <= '0;
    end
    else
    begin
      ovS1_r   <= overvoltageDetect;
      ovSync_r <= ovS1_r;
      shS1_r   <= shortAbove;
      shSync_r <= shS1_r;
    end
  end

  assign faultClr  = {CH_NUM{commit}}
                   & {{4{dirty_r[ADR_FAULT_HI]}}, {8{dirty_r[ADR_FAULT_LO]}}}
                   & ~{stage_r[ADR_FAULT_HI][3:0], stage_r[ADR_FAULT_LO]};
  assign shortMiss = {CH_NUM{periodEnd}} & wasOn_r & ~shortSeen_r & ~ovLatch_r;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wasOn_r     <= '0;
      shortSeen_r <= '0;
    end
    else if (periodEnd)
    begin
      wasOn_r     <= '0;
      shortSeen_r <= '0;
    end
    else
    begin
      wasOn_r     <= wasOn_r | ledOn_r;
      shortSeen_r <= shortSeen_r | (shSync_r & ledOn_r);
    end
  end

  // Set wins over clear on all three so a fault in the clearing cycle survives
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovLatch_r   <= '0;
      faultPend_r <= '0;
      fault_r     <= '0;
    end
    else
    begin
      ovLatch_r   <= (ovLatch_r & ~faultClr) | ovSync_r;
      faultPend_r <= (faultPend_r & ~matchOff) | ovSync_r | shortMiss;
      fault_r     <= (fault_r & ~faultClr) | (faultPend_r & matchOff);
    end
  end

  // ==========================================================================
  // Communications watchdog
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      commState_r <= WD_IDLE;
      commCnt_r   <= '0;
    end
    else if (!system_config_register_r[CFG_CMW_BIT])
    begin
      commState_r <= WD_IDLE;
      commCnt_r   <= '0;
    end
    else
    begin
      unique case (commState_r)
        WD_IDLE:
        begin
          commState_r <= WD_ARMED;
          commCnt_r   <= '0;
        end
        WD_ARMED:
        begin
          if (commit)
            commCnt_r <= '0;
          else if (commCnt_r == COMM_LAST)
            commState_r <= WD_EXPIRED;
          else
            commCnt_r <= commCnt_r + 1'b1;
        end
        WD_EXPIRED:
        begin
          if (commit)
          begin
            commState_r <= WD_ARMED;
            commCnt_r   <= '0;
          end
        end
      endcase
    end
  end

  assign commExpired = (commState_r == WD_EXPIRED);

  // ==========================================================================
  // Clock watchdog on the local oscillator
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      clkToggle_r <= 1'b0;
    else
      clkToggle_r <= ~clkToggle_r;
  end

  always_ff @(posedge oscClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tgS1_r <= 1'b0;
      tgS2_r <= 1'b0;
      tgS3_r <= 1'b0;
      enS1_r <= 1'b0;
      enS2_r <= 1'b0;
    end
    else
    begin
      tgS1_r <= clkToggle_r;
      tgS2_r <= tgS1_r;
      tgS3_r <= tgS2_r;
      enS1_r <= system_config_register_r[CFG_CKW_BIT];
      enS2_r <= enS1_r;
    end
  end

  // Counting stays in the oscillator domain because mclk itself may be the thing that died
  always_ff @(posedge oscClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oscCnt_r  <= 6'h00;
      clkLost_r <= 1'b0;
    end
    else if (!enS2_r || (tgS2_r != tgS3_r))
    begin
      oscCnt_r  <= 6'h00;
      clkLost_r <= 1'b0;
    end
    else if (oscCnt_r == OSC_LAST)
      clkLost_r <= 1'b1;
    else
      oscCnt_r <= oscCnt_r + 6'h01;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lostS1_r <= 1'b0;
      lostS2_r <= 1'b0;
    end
    else
    begin
      lostS1_r <= clkLost_r;
      lostS2_r <= lostS1_r;
    end
  end

  // ==========================================================================
  // LED drive; overvoltage pin acts combinationally so no clock edge is needed
  assign ledLit = ((clkLost_r | commExpired) ? default_led_state_register_r : ledOn_r)
                & ~(ovLatch_r | overvoltageDetect);

  // ==========================================================================
  // Register read
  always_comb
  begin
    rdNext = 8'h00;
    for (int ch = 0; ch < CH_NUM; ch++)
    begin
      if (busReq.addr == chAdr(ADR_ON_LO, ch))
        rdNext = onHold_r[ch][7:0];
      if (busReq.addr == chAdr(ADR_ON_HI, ch))
        rdNext = hiByte(onHold_r[ch]);
      if (busReq.addr == chAdr(ADR_OFF_LO, ch))
        rdNext = offHold_r[ch][7:0];
      if (busReq.addr == chAdr(ADR_OFF_HI, ch))
        rdNext = hiByte(offHold_r[ch]);
    end
    if (busReq.addr == ADR_CHANNEL_COMPARE_ENABLE_LO)
      rdNext = enable_r[7:0];
    if (busReq.addr == ADR_CHANNEL_COMPARE_ENABLE_HI)
      rdNext = {4'h0, enable_r[11:8]};
    if (busReq.addr == ADR_SYSTEM_CONFIG_REGISTER)
      rdNext = {4'h0, commExpired, lostS2_r, system_config_register_r};
    if (busReq.addr == ADR_DEFAULT_LED_STATE_REGISTER_LO)
      rdNext = default_led_state_register_r[7:0];
    if (busReq.addr == ADR_DEFAULT_LED_STATE_REGISTER_HI)
      rdNext = {4'h0, default_led_state_register_r[11:8]};
    if (busReq.addr == ADR_FAULT_LO)
      rdNext = fault_r[7:0];
    if (busReq.addr == ADR_FAULT_HI)
      rdNext = {4'h0, fault_r[11:8]};
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rdData <= 8'h00;
    else
      rdData <= busReq.rd ? rdNext : 8'h00;
  end

  // ==========================================================================
  // Checks
  for (genvar i = 0; i < CH_NUM; i++)
  begin : g_chk
    a_off_priority: assert property (@(posedge mclk) disable iff (!reset_n)
      matchOff[i] |=> !ledOn_r[i])
      else $error("off match did not turn LED off");

    a_on_match: assert property (@(posedge mclk) disable iff (!reset_n)
      matchOn[i] && !matchOff[i] && enable_r[i] |=> ledOn_r[i])
      else $error("on match did not turn LED on");

    a_off_staged: assert property (@(posedge mclk) disable iff (!reset_n)
      matchOn[i] |=> offAct_r[i] == $past(offHold_r[i]))
      else $error("off value not moved at on match");

    a_on_staged: assert property (@(posedge mclk) disable iff (!reset_n)
      matchOff[i] |=> onAct_r[i] == $past(onHold_r[i]))
      else $error("on value not moved at off match");

    a_fault_post: assert property (@(posedge mclk) disable iff (!reset_n)
      faultPend_r[i] && matchOff[i] ##1 !faultClr[i] |-> fault_r[i])
      else $error("pending fault not posted at off match");

    a_enable_gate: assert property (@(posedge mclk) disable iff (!reset_n)
      !enable_r[i] |=> !ledOn_r[i])
      else $error("disabled channel still switching");
  end

  a_crc_discard: assert property (@(posedge mclk) disable iff (!reset_n)
    frameBad |=> dirty_r == '0 && $stable(enable_r) && $stable(default_led_state_register_r) && $stable(system_config_register_r))
    else $error("bad frame changed registers");

  a_comm_expire: assert property (@(posedge mclk) disable iff (!reset_n)
    commState_r == WD_ARMED && commCnt_r == COMM_LAST && !commit && system_config_register_r[CFG_CMW_BIT]
    |=> commExpired)
    else $error("comm watchdog did not expire");

  a_comm_resume: assert property (@(posedge mclk) disable iff (!reset_n)
    commExpired && commit && system_config_register_r[CFG_CMW_BIT] |=> !commExpired ##1 !commExpired)
    else $error("valid frame did not end comm forcing");

  a_wd_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    !system_config_register_r[CFG_CMW_BIT] |=> commState_r == WD_IDLE)
    else $error("comm watchdog ran while disabled");

  a_clk_lost: assert property (@(posedge oscClk) disable iff (!reset_n)
    enS2_r && tgS2_r == tgS3_r && oscCnt_r == OSC_LAST |=> clkLost_r)
    else $error("clock watchdog did not expire");

  a_forced_state: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(commExpired) && ovLatch_r == '0 && overvoltageDetect == '0 |-> ledLit == default_led_state_register_r)
    else $error("forced LED state not from default register");

endmodule

// *** inc/lbp_pkg.sv ***
// Purpose: Shared constants and carrier types for the LED bypass PWM block
// Assumes: Byte-wide register space, twelve channels, 10-bit period counter
// Notes:   Reset values mirror a closed bypass switch on every channel

package lbp_pkg;

  // ==========================================================================
  // Sizes
  localparam int CH_NUM = 12;
  localparam int CNT_W  = 10;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] ADR_ON_LO     = 7'h00;
  localparam logic [ADDR_W-1:0] ADR_ON_HI     = 7'h10;
  localparam logic [ADDR_W-1:0] ADR_OFF_LO    = 7'h20;
  localparam logic [ADDR_W-1:0] ADR_OFF_HI    = 7'h30;
  localparam logic [ADDR_W-1:0] ADR_CHANNEL_COMPARE_ENABLE_LO   = 7'h40;
  localparam logic [ADDR_W-1:0] ADR_CHANNEL_COMPARE_ENABLE_HI   = 7'h41;
  localparam logic [ADDR_W-1:0] ADR_SYSTEM_CONFIG_REGISTER    = 7'h42;
  localparam logic [ADDR_W-1:0] ADR_DEFAULT_LED_STATE_REGISTER_LO = 7'h43;
  localparam logic [ADDR_W-1:0] ADR_DEFAULT_LED_STATE_REGISTER_HI = 7'h44;
  localparam logic [ADDR_W-1:0] ADR_FAULT_LO  = 7'h45;
  localparam logic [ADDR_W-1:0] ADR_FAULT_HI  = 7'h46;
  localparam logic [ADDR_W-1:0] ADR_LIMIT     = 7'h47;
  localparam int                REG_COUNT     = 71;

  // ==========================================================================
  // Field positions of the system config register
  localparam int CFG_CKW_BIT = 0;
  localparam int CFG_CMW_BIT = 1;
  localparam int CFG_CKL_BIT = 2;
  localparam int CFG_CMX_BIT = 3;

  // ==========================================================================
  // Reset values
  localparam logic [CNT_W-1:0]  RST_COUNT  = 10'h000;
  localparam logic [CH_NUM-1:0] RST_CHAN   = 12'h000;
  localparam logic [1:0]        RST_SYSTEM_CONFIG_REGISTER = 2'h0;

  // ==========================================================================
  // Timing counts
  localparam int          CLK_WD_OSC_CYCLES   = 32;
  localparam int          COMM_WD_LOG2        = 22;
  localparam int unsigned COMM_WD_CYCLES_DFLT = 32'h1 << COMM_WD_LOG2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lbp_req_s;

  typedef struct packed {
    logic done;
    logic crcOk;
  } lbp_frame_s;

  typedef enum {WD_IDLE, WD_ARMED, WD_EXPIRED} lbp_wd_e;

endpackage

// *** tb/lbp_host_model.sv ***
// Purpose: Host side frame source, ends each frame with a CRC verdict
// Assumes: One frame end per request pulse, on the core clock
// Notes:   crcOk is scrambled outside the done cycle, as it means nothing there

module lbp_host_model
  import lbp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic go,
  input  wire logic goodCrc,
  output lbp_frame_s frameOut
);
  timeunit 1ns;
  timeprecision 1ns;

  // ====
  // Frame end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      frameOut <= '0;
    else
    begin
      frameOut.done  <= go;
      frameOut.crcOk <= go ? goodCrc : ~frameOut.crcOk;
    end
  end
endmodule

// *** tb/lbp_core_tb.sv ***
// Purpose: Register, PWM, fault and watchdog checks of the bypass core
// Assumes: Writes commit through host frames; comm watchdog shortened to 64 cycles
// Notes:   shortAbove follows ledLit, modelling a healthy LED unless masked

module lbp_core_tb
  import lbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PER = 1 << CNT_W;

  logic              mclk       = 1'b0;
  logic              oscClk     = 1'b0;
  logic              reset_n    = 1'b0;
  logic              clkRun     = 1'b1;
  lbp_req_s          busReq     = '0;
  lbp_frame_s        frameIn;
  logic              pwmTick    = 1'b0;
  logic              frameGo    = 1'b0;
  logic              frameOk    = 1'b0;
  logic [CH_NUM-1:0] ovDet      = '0;
  logic [CH_NUM-1:0] shortAbove = '0;
  logic [CH_NUM-1:0] shortMask  = '0;
  logic [DATA_W-1:0] rdData;
  logic [CH_NUM-1:0] ledLit;
  logic              uartHold;
  logic              holdSeen   = 1'b0;
  logic [DATA_W-1:0] rv;
  int                errCount   = 0;
  int                compares   = 0;
  int                cnt        = 0;

  // ====
  // Clocks; mclk can be stopped to starve the clock watchdog
  initial
  begin
    forever
    begin
      #25;
      if (clkRun)
        mclk = ~mclk;
    end
  end

  initial
  begin
    forever #20 oscClk = ~oscClk;
  end

  always @(posedge mclk)
    shortAbove <= ledLit & ~shortMask;

  // Sticky record that the bus was held off while the clock was lost
  always @(posedge mclk)
    if (uartHold)
      holdSeen <= 1'b1;

  // ====
  // Design and host
  lbp_core #(
    .COMM_WD_CYCLES (64)
  ) dut (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .oscClk            (oscClk),
    .busReq            (busReq),
    .frameIn           (frameIn),
    .pwmTick           (pwmTick),
    .overvoltageDetect (ovDet),
    .shortAbove        (shortAbove),
    .rdData            (rdData),
    .ledLit            (ledLit),
    .uartHold          (uartHold)
  );

  lbp_host_model host (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .go       (frameGo),
    .goodCrc  (frameOk),
    .frameOut (frameIn)
  );

  // ====
  // Tasks
  task automatic results;
    $display("Compares %0d, mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    busReq <= '0;
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge mclk);
    busReq <= '0;
    #1 rv = rdData;
    check(rv, exp);
  endtask

  // Writes must not meet the done cycle, so the frame starts on a fresh edge
  task automatic frame(input logic ok);
    @(posedge mclk);
    frameGo <= 1'b1;
    frameOk <= ok;
    @(posedge mclk);
    frameGo <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic runTo(input int t);
    repeat ((t - cnt + PER) % PER)
    begin
      @(posedge mclk);
      pwmTick <= 1'b1;
      @(posedge mclk);
      pwmTick <= 1'b0;
    end
    cnt = t;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  initial
  begin
    #3000000;
    errCount++;
    results;
  end

  // ====
  // Tests
  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rc(ADR_SYSTEM_CONFIG_REGISTER, 8'h00);
    rc(ADR_FAULT_LO, 8'h00);
    wr(ADR_ON_LO, 8'h34);
    wr(ADR_ON_HI, 8'h01);
    rc(ADR_ON_LO, 8'h00);
    frame(1'b0);
    rc(ADR_ON_HI, 8'h00);
    wr(ADR_ON_LO, 8'h34);
    wr(ADR_ON_HI, 8'h01);
    frame(1'b1);
    rc(ADR_ON_LO, 8'h34);
    rc(ADR_ON_HI, 8'h01);
    wr(ADR_ON_LO, 8'h02);
    wr(ADR_ON_HI, 8'h00);
    wr(ADR_OFF_LO, 8'h08);
    wr(ADR_CHANNEL_COMPARE_ENABLE_LO, 8'h01);
    wr(7'h50, 8'hff);
    frame(1'b1);
    rc(7'h50, 8'h00);
    runTo(PER - 1);
    runTo(3);
    check(ledLit[0], 1'b1);
    wr(ADR_OFF_LO, 8'h0c);
    frame(1'b1);
    runTo(9);
    check(ledLit[0], 1'b0);
    runTo(3);
    runTo(10);
    check(ledLit[0], 1'b1);
    runTo(13);
    wr(ADR_ON_LO, 8'h07);
    frame(1'b1);
    runTo(3);
    check(ledLit[0], 1'b1);
    runTo(13);
    runTo(3);
    check(ledLit[0], 1'b0);
    // On-time of five counts keeps fault reports valid
    runTo(8);
    check(ledLit[0], 1'b1);
    ovDet <= 12'h001;
    #1 check(ledLit[0], 1'b0);
    repeat (4) @(posedge mclk);
    ovDet <= '0;
    rc(ADR_FAULT_LO, 8'h00);
    runTo(13);
    rc(ADR_FAULT_LO, 8'h01);
    rc(ADR_FAULT_HI, 8'h00);
    wr(ADR_FAULT_LO, 8'h00);
    frame(1'b1);
    rc(ADR_FAULT_LO, 8'h00);
    shortMask <= 12'h001;
    runTo(8);
    check(ledLit[0], 1'b1);
    runTo(3);
    runTo(13);
    rc(ADR_FAULT_LO, 8'h01);
    shortMask <= '0;
    // Dim to zero: off to on plus one, then drop the enable bit
    wr(ADR_OFF_LO, 8'h08);
    frame(1'b1);
    runTo(9);
    check(ledLit[0], 1'b0);
    wr(ADR_CHANNEL_COMPARE_ENABLE_LO, 8'h00);
    frame(1'b1);
    runTo(7);
    check(ledLit[0], 1'b0);
    wr(ADR_DEFAULT_LED_STATE_REGISTER_LO, 8'h02);
    frame(1'b1);
    clkRun = 1'b0;
    #3000;
    check(ledLit, 12'h000);
    check(holdSeen, 1'b0);
    clkRun = 1'b1;
    wr(ADR_SYSTEM_CONFIG_REGISTER, 8'h01);
    frame(1'b1);
    repeat (4) @(posedge mclk);
    clkRun = 1'b0;
    #3000;
    check(ledLit, 12'h002);
    clkRun = 1'b1;
    repeat (8) @(posedge mclk);
    #1 check(ledLit, 12'h000);
    check(uartHold, 1'b0);
    check(holdSeen, 1'b1);
    rc(ADR_ON_LO, 8'h07);
    wr(ADR_SYSTEM_CONFIG_REGISTER, 8'h03);
    frame(1'b1);
    repeat (100) @(posedge mclk);
    #1 check(ledLit, 12'h002);
    rc(ADR_SYSTEM_CONFIG_REGISTER, 8'h0b);
    frame(1'b0);
    #1 check(ledLit, 12'h002);
    frame(1'b1);
    #1 check(ledLit, 12'h000);
    results;
  end
endmodule
